// file: include/mis_defines.svh
// constants for the instruction-subset execution core: register offsets,
// field positions, reset values and opcode patterns.
// assumes a 12-bit apb byte address and 32-bit apb data.
`ifndef MIS_DEFINES_SVH
`define MIS_DEFINES_SVH

// ************************************************************
// apb register byte offsets
// ************************************************************
`define MIS_OFF_CTRL 12'h000
`define MIS_OFF_STATUS 12'h004
`define MIS_OFF_ACC 12'h008
`define MIS_OFF_INTCTL 12'h00C
`define MIS_OFF_OPTION 12'h010
`define MIS_OFF_UPLATCH 12'h014
`define MIS_OFF_PC 12'h018

// ************************************************************
// field positions
// ************************************************************
`define MIS_CTRL_RUN_BIT 0
`define MIS_STAT_ZERO_BIT 0
`define MIS_STAT_IDLE_BIT 1
`define MIS_GIE_BIT 7
`define MIS_UPLATCH_HI 4
`define MIS_UPLATCH_LO 3

// ************************************************************
// reset values
// ************************************************************
`define MIS_RST_RUN 1'b1
`define MIS_RST_INTCTL 8'h00
`define MIS_RST_OPTION 8'h00
`define MIS_RST_UPLATCH 5'h00
`define MIS_RST_PC 13'h0000
`define MIS_RST_ACC 8'h00

// ************************************************************
// opcode patterns
// ************************************************************
`define MIS_OPC_INC_FILE 6'h0A
`define MIS_OPC_INC_SKIP 6'h0F
`define MIS_OPC_OR_FILE 6'h04
`define MIS_OPC_MOVE_FILE 6'h08
`define MIS_OPC_OR_LIT 6'h38
`define MIS_OPC_STORE 7'h01
`define MIS_OPC_LOAD_LIT 4'hC
`define MIS_OPC_RET_LIT 4'hD
`define MIS_OPC_BRANCH 3'h5
`define MIS_ENC_RET_INT 14'h0009
`define MIS_ENC_OPT_LOAD 14'h0062
`define MIS_NOP_MASK 14'h3F9F

`endif

// file: include/mis_pkg.sv
// types shared by the execution core and its decoder.
// assumes nothing beyond a systemverilog compiler.
package mis_pkg;

    // instruction cycle phase
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mis_phase_t;

    // decoded operation
    typedef enum logic [3:0] {
        OP_NO_OPERATION, OP_INC_FILE, OP_INC_SKIP, OP_OR_LIT, OP_OR_FILE,
        OP_MOVE_FILE, OP_LOAD_LIT, OP_STORE, OP_RET_INT, OP_OPT_LOAD,
        OP_BRANCH, OP_RET_LIT, OP_OTHER
    } mis_op_t;

    // decoded instruction fields
    typedef struct packed {
        mis_op_t op;
        logic dest;
        logic [6:0] fileAddr;
        logic [7:0] literal;
        logic [10:0] target;
    } mis_dec_t;

endpackage

// file: include/mis_dec_if.sv
// carries the raw instruction word to the decoder and the decoded fields back.
// assumes mis_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
interface mis_dec_if;
    import mis_pkg::*;
    logic [13:0] instr; // raw word from program memory
    mis_dec_t dec; // decoded fields
    modport decoder (input instr, output dec);
    modport core (output instr, input dec);
endinterface
`default_nettype wire

// file: core/mis_decoder.sv
// combinational decoder for the supported instruction subset.
// assumes the word is stable during phase q1.
`timescale 1ns/1ps
`default_nettype none
`include "mis_defines.svh"
module mis_decoder
    import mis_pkg::*;
(
    mis_dec_if.decoder dif
);

    // ************************************************************
    // decode
    // ************************************************************
    // anything outside the subset decodes as other and runs as a quiet cycle
    function automatic mis_dec_t decode(input logic [13:0] w);
        mis_dec_t d;
        d.op = OP_OTHER;
        d.dest = w[7];
        d.fileAddr = w[6:0];
        d.literal = w[7:0];
        d.target = w[10:0];
        if (w == `MIS_ENC_RET_INT) begin
            d.op = OP_RET_INT;
        end else if (w == `MIS_ENC_OPT_LOAD) begin
            d.op = OP_OPT_LOAD;
        end else if ((w & `MIS_NOP_MASK) == 14'h0000) begin
            d.op = OP_NO_OPERATION; // bits 6:5 are don't care
        end else if (w[13:7] == `MIS_OPC_STORE) begin
            d.op = OP_STORE;
        end else if (w[13:8] == `MIS_OPC_INC_FILE) begin
            d.op = OP_INC_FILE;
        end else if (w[13:8] == `MIS_OPC_INC_SKIP) begin
            d.op = OP_INC_SKIP;
        end else if (w[13:8] == `MIS_OPC_OR_FILE) begin
            d.op = OP_OR_FILE;
        end else if (w[13:8] == `MIS_OPC_MOVE_FILE) begin
            d.op = OP_MOVE_FILE;
        end else if (w[13:8] == `MIS_OPC_OR_LIT) begin
            d.op = OP_OR_LIT;
        end else if (w[13:10] == `MIS_OPC_LOAD_LIT) begin
            d.op = OP_LOAD_LIT; // bits 9:8 ignored
        end else if (w[13:10] == `MIS_OPC_RET_LIT) begin
            d.op = OP_RET_LIT;
        end else if (w[13:11] == `MIS_OPC_BRANCH) begin
            d.op = OP_BRANCH;
        end
        return d;
    endfunction

    assign dif.dec = decode(dif.instr);

endmodule // mis_decoder
`default_nettype wire

// file: core/mis_exec_core.sv
// execution core for a subset of a 14-bit instruction set, four clocks
// per instruction cycle, with an apb slave for control and visibility.
// assumes program memory answers combinationally on progAddr and the file
// register datapath answers fileRdata in the same cycle as fileRead.
`timescale 1ns/1ps
`default_nettype none
`include "mis_defines.svh"
// What this block does
// - destination bit picks accumulator or file register
// - increment file, route result, update zero
// - increment-skip routes result, flags untouched
// - zero result discards next, idle cycle
// - or literal into accumulator, update zero
// - or accumulator with file, route, zero
// - move file to accumulator or itself
// - move updates zero from moved value
// - load literal, no flags, ignore don't-cares
// - store accumulator to file, no flags
// - interrupt return pops, sets enable in q3
// - option load copies accumulator in one cycle
// - branch loads target plus latch bits 4:3
// - literal return loads accumulator, pops, two cycles
module mis_exec_core
    import mis_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [12:0] progAddr,
    input wire logic [13:0] instrWord,
    output logic [6:0] fileAddr,
    output logic fileRead,
    input wire logic [7:0] fileRdata,
    output logic fileWrite,
    output logic [7:0] fileWdata,
    input wire logic [12:0] stackTop,
    output logic stackPop,
    output logic globalIntEnable,
    output logic [7:0] optionReg
);

    // ************************************************************
    // declarations
    // ************************************************************
    mis_dec_if dif (); // decoder link
    mis_phase_t phase_r; // current phase
    mis_dec_t decR_r; // instruction latched at end of q1
    logic runEn_r; // software run enable
    logic curIdle_r; // this cycle is a discarded slot
    logic idleAdv_r; // the idle slot still advances the counter
    logic flushNext_r; // next cycle must be idle
    logic flushAdv_r; // that idle cycle advances the counter
    logic [7:0] operand_r; // value read in q2
    logic [7:0] result_r; // value computed in q3
    logic [7:0] acc_r; // working accumulator
    logic zero_r; // zero flag
    logic [12:0] pc_r; // program counter
    logic [7:0] intCtrl_r; // interrupt control register
    logic [7:0] option_r; // option configuration register
    logic [4:0] upLatch_r; // upper address latch
    logic [7:0] fileWdata_r; // file write data
    logic [31:0] prdata_r; // apb read data
    logic pslverr_r; // apb error for the held request
    logic stepQ1, stepQ2, stepQ3, stepQ4; // phase completes this edge
    logic exec; // a real instruction occupies this cycle
    logic fileOp; // operand comes from the file register
    logic writeFile; // q4 writes the file register
    logic writeAcc; // q4 writes the accumulator
    logic updZero; // q4 updates the zero flag
    logic apbSetup; // setup cycle of a transfer
    logic apbWrite; // access cycle of a write
    logic hwGieSet; // interrupt return sets the enable

    // ************************************************************
    // decoder
    // ************************************************************
    assign dif.instr = instrWord;

    mis_decoder u_dec (
        .dif(dif.decoder)
    );

    // ************************************************************
    // phase sequencing
    // ************************************************************
    assign stepQ1 = runEn_r && (phase_r == PH_Q1);
    assign stepQ2 = runEn_r && (phase_r == PH_Q2);
    assign stepQ3 = runEn_r && (phase_r == PH_Q3);
    assign stepQ4 = runEn_r && (phase_r == PH_Q4);

    // four phases per instruction cycle; a stopped core freezes in place
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_r <= PH_Q1;
        end else if (runEn_r) begin
            unique case (phase_r)
                PH_Q1: phase_r <= PH_Q2;
                PH_Q2: phase_r <= PH_Q3;
                PH_Q3: phase_r <= PH_Q4;
                PH_Q4: phase_r <= PH_Q1;
            endcase
        end
    end

    // ************************************************************
    // q1: decode and latch
    // ************************************************************
    // the decoded word is held for the whole cycle so the memory may move on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            decR_r <= '0;
            curIdle_r <= 1'b0;
            idleAdv_r <= 1'b0;
        end else if (stepQ1) begin
            decR_r <= dif.dec;
            curIdle_r <= flushNext_r; // discarded slot acts as idle
            idleAdv_r <= flushAdv_r;
        end
    end

    // ************************************************************
    // operation classes
    // ************************************************************
    assign exec = !curIdle_r;
    assign fileOp = (decR_r.op == OP_INC_FILE) || (decR_r.op == OP_INC_SKIP) ||
                    (decR_r.op == OP_OR_FILE) || (decR_r.op == OP_MOVE_FILE) ||
                    (decR_r.op == OP_STORE);
    // store always targets the file; others follow the destination bit
    assign writeFile = fileOp && ((decR_r.op == OP_STORE) || decR_r.dest);
    assign writeAcc = (decR_r.op == OP_OR_LIT) || (decR_r.op == OP_LOAD_LIT) ||
                      (decR_r.op == OP_RET_LIT) ||
                      (fileOp && (decR_r.op != OP_STORE) && !decR_r.dest);
    // skip, load, store and returns leave the flag alone
    assign updZero = (decR_r.op == OP_INC_FILE) || (decR_r.op == OP_OR_LIT) ||
                     (decR_r.op == OP_OR_FILE) || (decR_r.op == OP_MOVE_FILE);

    // ************************************************************
    // q2: operand read
    // ************************************************************
    // idle slots issue no read
    assign fileRead = stepQ2 && exec && fileOp;
    assign fileAddr = decR_r.fileAddr;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            operand_r <= 8'h00;
        end else if (stepQ2) begin
            operand_r <= fileOp ? fileRdata : decR_r.literal;
        end
    end

    // ************************************************************
    // q3: process
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_r <= 8'h00;
            fileWdata_r <= 8'h00;
        end else if (stepQ3) begin
            unique case (decR_r.op)
                OP_INC_FILE, OP_INC_SKIP: begin
                    result_r <= operand_r + 8'h01;
                    fileWdata_r <= operand_r + 8'h01;
                end
                OP_OR_LIT, OP_OR_FILE: begin
                    result_r <= acc_r | operand_r;
                    fileWdata_r <= acc_r | operand_r;
                end
                OP_MOVE_FILE, OP_LOAD_LIT, OP_RET_LIT: begin
                    result_r <= operand_r;
                    fileWdata_r <= operand_r;
                end
                default: begin
                    // store and option load carry the accumulator
                    result_r <= acc_r;
                    fileWdata_r <= acc_r;
                end
            endcase
        end
    end

    assign hwGieSet = stepQ3 && exec && (decR_r.op == OP_RET_INT);

    // ************************************************************
    // q4: write back
    // ************************************************************
    assign fileWrite = stepQ4 && exec && writeFile;
    assign fileWdata = fileWdata_r;
    assign stackPop = stepQ4 && exec &&
                      ((decR_r.op == OP_RET_INT) || (decR_r.op == OP_RET_LIT));

    // accumulator and zero flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_r <= `MIS_RST_ACC;
            zero_r <= 1'b0;
        end else if (stepQ4 && exec) begin
            if (writeAcc) begin
                acc_r <= result_r;
            end
            if (updZero) begin
                zero_r <= (result_r == 8'h00);
            end
        end
    end

    // program counter; branch and returns load it and leave an idle slot
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_r <= `MIS_RST_PC;
        end else if (stepQ4) begin
            if (curIdle_r) begin
                // a skipped slot steps over the discarded word; a branch
                // slot holds the counter so the target is fetched next
                if (idleAdv_r) begin
                    pc_r <= pc_r + 13'h0001;
                end
            end else begin
                unique case (decR_r.op)
                    OP_BRANCH: pc_r <= {upLatch_r[`MIS_UPLATCH_HI:`MIS_UPLATCH_LO],
                                        decR_r.target};
                    OP_RET_INT, OP_RET_LIT: pc_r <= stackTop;
                    default: pc_r <= pc_r + 13'h0001;
                endcase
            end
        end
    end

    // idle slot scheduling for two-cycle instructions
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flushNext_r <= 1'b0;
            flushAdv_r <= 1'b0;
        end else if (stepQ4) begin
            flushNext_r <= exec && ((decR_r.op == OP_BRANCH) ||
                           (decR_r.op == OP_RET_INT) || (decR_r.op == OP_RET_LIT) ||
                           ((decR_r.op == OP_INC_SKIP) && (result_r == 8'h00)));
            flushAdv_r <= exec && (decR_r.op == OP_INC_SKIP);
        end
    end

    assign progAddr = pc_r;

    // ************************************************************
    // apb slave
    // ************************************************************
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite;
    assign pready = psel && penable; // zero wait states
    assign pslverr = pready && pslverr_r;
    assign prdata = prdata_r;

    // address map check, shared by the read and write paths
    function automatic logic regMapped(input logic [11:0] a, input logic wr);
        logic ok;
        ok = 1'b0;
        unique case (a)
            `MIS_OFF_CTRL, `MIS_OFF_INTCTL, `MIS_OFF_OPTION, `MIS_OFF_UPLATCH: ok = 1'b1;
            `MIS_OFF_STATUS, `MIS_OFF_ACC, `MIS_OFF_PC: ok = !wr;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // read data and error are captured in setup so both come from flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (apbSetup) begin
            pslverr_r <= !regMapped(paddr, pwrite);
            prdata_r <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    `MIS_OFF_CTRL: prdata_r <= {31'h0, runEn_r};
                    `MIS_OFF_STATUS: prdata_r <= {30'h0, curIdle_r, zero_r};
                    `MIS_OFF_ACC: prdata_r <= {24'h0, acc_r};
                    `MIS_OFF_INTCTL: prdata_r <= {24'h0, intCtrl_r};
                    `MIS_OFF_OPTION: prdata_r <= {24'h0, option_r};
                    `MIS_OFF_UPLATCH: prdata_r <= {27'h0, upLatch_r};
                    `MIS_OFF_PC: prdata_r <= {19'h0, pc_r};
                    default: prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control and latch writes; only the access edge takes effect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            runEn_r <= `MIS_RST_RUN;
            upLatch_r <= `MIS_RST_UPLATCH;
        end else if (apbWrite && regMapped(paddr, 1'b1)) begin
            if (paddr == `MIS_OFF_CTRL) begin
                runEn_r <= pwdata[`MIS_CTRL_RUN_BIT];
            end
            if (paddr == `MIS_OFF_UPLATCH) begin
                upLatch_r <= pwdata[4:0];
            end
        end
    end

    // interrupt control; the hardware set beats a same-edge software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intCtrl_r <= `MIS_RST_INTCTL;
        end else begin
            if (apbWrite && (paddr == `MIS_OFF_INTCTL)) begin
                intCtrl_r <= pwdata[7:0];
            end
            if (hwGieSet) begin
                intCtrl_r[`MIS_GIE_BIT] <= 1'b1;
            end
        end
    end

    // option register; the instruction wins over a same-edge bus write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            option_r <= `MIS_RST_OPTION;
        end else if (stepQ4 && exec && (decR_r.op == OP_OPT_LOAD)) begin
            option_r <= result_r;
        end else if (apbWrite && (paddr == `MIS_OFF_OPTION)) begin
            option_r <= pwdata[7:0];
        end
    end

    assign globalIntEnable = intCtrl_r[`MIS_GIE_BIT];
    assign optionReg = option_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // a slot may stall while software holds the core, so quiet is checked per cycle
    sequence sQuietCycle;
        !fileRead && !fileWrite && !stackPop;
    endsequence

    sequence sSkipZero;
        stepQ4 && exec && (decR_r.op == OP_INC_SKIP) && (result_r == 8'h00);
    endsequence

    sequence sReturnQ4;
        stepQ4 && exec && ((decR_r.op == OP_RET_INT) || (decR_r.op == OP_RET_LIT));
    endsequence

    a_dest_acc_only: assert property (
        (stepQ4 && exec && fileOp && (decR_r.op != OP_STORE) && !decR_r.dest)
        |-> !fileWrite)
        else $error("destination 0 wrote the file register");

    a_inc_result: assert property (
        (stepQ4 && exec && (decR_r.op == OP_INC_FILE) && !decR_r.dest)
        |=> (acc_r == 8'($past(operand_r) + 8'h01)) && (zero_r == (acc_r == 8'h00)))
        else $error("increment result or zero flag wrong");

    a_skip_flags: assert property (
        (stepQ4 && exec && (decR_r.op == OP_INC_SKIP)) |=> $stable(zero_r))
        else $error("increment-skip changed the zero flag");

    // the skip steps over one word and books an idle slot that steps once more
    a_skip_idle: assert property (
        sSkipZero |=> flushNext_r && flushAdv_r && (pc_r == 13'($past(pc_r) + 13'h0001)))
        else $error("skip slot not scheduled");

    a_skip_quiet: assert property (
        curIdle_r |-> sQuietCycle)
        else $error("discarded slot was not idle");

    a_or_literal: assert property (
        (stepQ4 && exec && (decR_r.op == OP_OR_LIT))
        |=> acc_r == ($past(acc_r) | $past(operand_r)))
        else $error("or literal result wrong");

    a_move_zero: assert property (
        (stepQ4 && exec && (decR_r.op == OP_MOVE_FILE))
        |=> zero_r == ($past(operand_r) == 8'h00))
        else $error("move did not set zero from moved value");

    a_literal_load: assert property (
        (stepQ4 && exec && (decR_r.op == OP_LOAD_LIT))
        |=> $stable(zero_r) && (acc_r == $past(operand_r)))
        else $error("literal load wrong or touched the flag");

    a_store_acc: assert property (
        (stepQ4 && exec && (decR_r.op == OP_STORE)) |-> fileWrite && (fileWdata == acc_r))
        else $error("store did not write the accumulator");

    a_gie_q3: assert property (
        (stepQ3 && exec && (decR_r.op == OP_RET_INT)) |=> globalIntEnable)
        else $error("interrupt return did not set the enable in q3");

    a_return_pop: assert property (
        sReturnQ4 |-> stackPop ##1 ((pc_r == $past(stackTop)) && flushNext_r))
        else $error("return did not pop into the counter");

    a_option_load: assert property (
        (stepQ4 && exec && (decR_r.op == OP_OPT_LOAD)) |=> optionReg == $past(acc_r))
        else $error("option load did not copy the accumulator");

    a_branch_pc: assert property (
        (stepQ4 && exec && (decR_r.op == OP_BRANCH))
        |=> pc_r == {$past(upLatch_r[4:3]), $past(decR_r.target)})
        else $error("branch target wrong");

    // a held core stalls, so each running edge is checked on its own
    a_phase_walk: assert property (
        runEn_r |=> phase_r == mis_phase_t'($past(phase_r) + 2'h1))
        else $error("phase order broken");

    a_nop_cycle: assert property (
        (stepQ4 && exec && (decR_r.op == OP_NO_OPERATION))
        |=> $stable(acc_r) && $stable(zero_r) && (pc_r == 13'($past(pc_r) + 13'h0001)))
        else $error("no operation changed state");

endmodule // mis_exec_core
`default_nettype wire

// file: verification/mcu_instruction_subset_exec_tb_top.sv
// bench for the instruction-subset core: steps a short program and checks state.
// assumes program memory and file registers answer combinationally, as modelled here.
`timescale 1ns/1ps
`default_nettype none
`include "mis_defines.svh"
`define CHK(g, w) begin compares++; if ((g) !== (w)) begin err_total++; \
    $display("unexpected t=%0t got=%0h want=%0h", $time, g, w); end end
module mcu_instruction_subset_exec_tb_top;
    import mis_pkg::*;
    // ************************************************************
    // stimulus, memories and expected rows
    // ************************************************************
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdData;
    logic pready, pslverr, errFlag, fileRead, fileWrite, stackPop, globalIntEnable;
    logic [12:0] progAddr, stackTop = 13'h0010;
    logic [6:0] fileAddr;
    logic [7:0] fileWdata, optionReg, fileRdata;
    logic [13:0] instrWord, progMem [8192];
    logic [7:0] fileMem [128];
    int err_total = 0, compares = 0, cyc = 0, reads = 0, pops = 0;
    // program words 0..14; word 11 is skipped and must never load the accumulator
    logic [13:0] code [15] = '{14'h3000, 14'h3800, 14'h3312, 14'h00A0, 14'h0A21, 14'h0AA0,
        14'h0422, 14'h08A3, 14'h3800, 14'h0062, 14'h0FA1, 14'h3077, 14'h0F20, 14'h0000, 14'h0009};
    // each row: program counter, accumulator, zero flag after one step
    logic [31:0] rows [17] = '{32'h00010000, 32'h00020001, 32'h00031201, 32'h00041201,
        32'h00050001, 32'h00060000, 32'h00078100, 32'h00088101, 32'h00098100, 32'h000A8100,
        32'h000B8100, 32'h000C8100, 32'h000D1400, 32'h000E1400, 32'h00101400, 32'h1FFF1400,
        32'h00103C00};
    assign instrWord = progMem[progAddr];
    assign fileRdata = fileMem[fileAddr];
    mis_exec_core DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .progAddr(progAddr), .instrWord(instrWord), .fileAddr(fileAddr),
        .fileRead(fileRead), .fileRdata(fileRdata), .fileWrite(fileWrite),
        .fileWdata(fileWdata), .stackTop(stackTop), .stackPop(stackPop),
        .globalIntEnable(globalIntEnable), .optionReg(optionReg));
    // clock at 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end
    // file register model: takes the write pulse at the edge ending q4
    always @(posedge clk) begin
        if (fileWrite === 1'b1) begin
            fileMem[fileAddr] <= fileWdata;
        end
        reads += (fileRead === 1'b1); // operand reads, one per file instruction
        pops += (stackPop === 1'b1); // stack pops, one per return
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            end_of_test();
        end
    end
    // ************************************************************
    // tasks
    // ************************************************************
    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1); // only the hang guard ends a wait
        rdData = prdata;
        errFlag = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // let the core run until the program counter moves, then freeze it again
    task automatic step();
        logic [12:0] old;
        old = progAddr;
        apb(1'b1, `MIS_OFF_CTRL, 32'h1);
        while (progAddr === old) begin
            @(posedge clk);
        end
        apb(1'b1, `MIS_OFF_CTRL, 32'h0);
    endtask
    task automatic end_of_test();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        for (int i = 0; i < 8192; i++) progMem[i] = (i < 15) ? code[i] : 14'h0000;
        for (int i = 0; i < 128; i++) fileMem[i] = 8'h00;
        progMem[16] = 14'h2FFF; // branch to the top of the space
        progMem[8191] = 14'h343C; // literal return
        fileMem[7'h21] = 8'hFF; // wraps to zero on increment
        fileMem[7'h22] = 8'h81;
        repeat (12) @(posedge clk);
        `CHK({optionReg, globalIntEnable, progAddr}, 22'h000000)
        rst_n <= 1'b1;
        apb(1'b1, `MIS_OFF_CTRL, 32'h0); // freeze inside the first instruction
        apb(1'b1, `MIS_OFF_UPLATCH, 32'h18);
        apb(1'b0, `MIS_OFF_INTCTL, 32'h0);
        `CHK(rdData, 32'h0)
        apb(1'b1, `MIS_OFF_ACC, 32'h55); // read-only: refused
        `CHK(errFlag, 1'b1)
        apb(1'b0, 12'h01C, 32'h0); // unmapped
        `CHK({errFlag, rdData}, 33'h100000000)
        for (int i = 0; i < 17; i++) begin
            step();
            `CHK(progAddr, rows[i][28:16])
            apb(1'b0, `MIS_OFF_ACC, 32'h0);
            `CHK(rdData[7:0], rows[i][15:8])
            apb(1'b0, `MIS_OFF_STATUS, 32'h0);
            `CHK(rdData[0], rows[i][0])
        end
        `CHK(globalIntEnable, 1'b1)
        `CHK(optionReg, 8'h81)
        `CHK(fileMem[7'h20], 8'h13)
        `CHK(fileMem[7'h21], 8'h00)
        `CHK(reads, 7)
        `CHK(pops, 2)
        rst_n <= 1'b0; // reset again in mid-run
        repeat (2) @(posedge clk);
        `CHK({optionReg, globalIntEnable, progAddr}, 22'h000000)
        rst_n <= 1'b1;
        apb(1'b0, `MIS_OFF_CTRL, 32'h0); // run enable is back on after reset
        `CHK(rdData, 32'h1)
        end_of_test();
    end
endmodule // mcu_instruction_subset_exec_tb_top
`default_nettype wire
